//--- src/pat_pkg.sv
// Shared constants and types of the protection auxiliary timer logic
package pat_pkg;
   localparam int CLK_HZ = 50_000_000;
   localparam int TICK_MS = 1;
   localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
   localparam int AUX_MAX_MS = 600_000;
   localparam int DLY_W = $clog2(AUX_MAX_MS + 1);
   localparam int AUX_N = 4;
   localparam int DIR_N = 2;
   localparam int AUX_MODE_W = 3;
   localparam int BF_MODE_W = 2;
   localparam int SY_AUX = 0;
   localparam int SY_DIR = 4;
   localparam int SY_EXT = 6;
   localparam int SY_CLOSED = 7;
   localparam int SY_LRST = 8;
   localparam int SY_W = 9;
   typedef enum logic [2:0] {
      AUX_OFF,
      AUX_ALARM,
      AUX_TRIP,
      AUX_INRUSH_BLOCKED_TRIP,
      AUX_LATCHED_TRIP,
      AUX_LOAD_SHED,
      AUX_RECLOSE_AFTER_SHED_HIGH,
      AUX_RECLOSE_AFTER_SHED_LOW
   } pat_aux_mode_t;
   typedef enum logic [1:0] {
      BF_DISABLED,
      BF_ALARM,
      BF_RETRIP,
      BF_SIGNAL
   } pat_bf_mode_t;
   typedef enum logic [1:0] {
      BF_SRC_INT,
      BF_SRC_AUX,
      BF_SRC_EXT
   } pat_bf_src_t;
endpackage

//--- src/pat_tmr_if.sv
// Control and expiry signals between the top and one delay timer
`timescale 1ns/100ps
`default_nettype none
interface pat_tmr_if #(parameter int W = 20);
   logic run;
   logic tick;
   logic [W-1:0] delay;
   logic expired;
   modport ctl(output run, output tick, output delay, input expired);
   modport tmr(input run, input tick, input delay, output expired);
endinterface
`default_nettype wire

//--- src/pat_aux_timer.sv
// Millisecond delay timer, cleared whenever its run condition drops
`timescale 1ns/100ps
`default_nettype none
module pat_aux_timer #(parameter int W = 20) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   pat_tmr_if.tmr t
);
   typedef struct packed {
      logic [W-1:0] cnt;
      logic expired;
   } pat_tmr_st_t;
   pat_tmr_st_t q;
   pat_tmr_st_t d;

   always_comb begin
      d = q;
      if (!t.run) begin
         d.cnt = '0;
         d.expired = 1'b0;
      end else begin
         if (t.tick && q.cnt != {W{1'b1}}) begin
            d.cnt = q.cnt + 1'b1;
         end
         d.expired = (q.cnt >= t.delay);
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         q <= '0;
      end else if (ce) begin
         q <= d;
      end
   end

   assign t.expired = q.expired;

   chk_tmr_clear_idle: assert property (@(posedge clk)
      disable iff (!rstn) ce && !t.run |=> !t.expired)
      else $error("timer expiry stands without run");
   chk_tmr_zero_delay: assert property (@(posedge clk)
      disable iff (!rstn) ce && t.run && t.delay == '0 |=> t.expired)
      else $error("zero delay did not expire at once");
endmodule
`default_nettype wire

//--- src/pat_top.sv
// Breaker-failure timer, auxiliary input timers and load-shed latch
`timescale 1ns/100ps
`default_nettype none
module pat_top #(
   parameter int TICK_CYC = pat_pkg::TICK_CYC,
   parameter int DW = pat_pkg::DLY_W
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   input wire logic [pat_pkg::AUX_N-1:0] aux_in,
   input wire logic direct_input_five,
   input wire logic direct_input_six,
   input wire logic external_breaker_fail_start,
   input wire logic breaker_closed_contact,
   input wire logic latch_reset_in,
   input wire logic panel_reset,
   input wire logic remote_reset,
   input wire logic close_signal,
   input wire logic int_trip,
   input wire logic phase_oc_start,
   input wire logic earth_oc_start,
   input wire logic phase_undercurrent_level,
   input wire logic earth_undercurrent_level,
   input wire logic inrush_block,
   input wire logic [pat_pkg::BF_MODE_W-1:0] bf_mode,
   input wire logic [DW-1:0] breaker_fail_delay,
   input wire logic cancel_phase_en,
   input wire logic cancel_earth_en,
   input wire logic [pat_pkg::AUX_N*pat_pkg::AUX_MODE_W-1:0] aux_mode,
   input wire logic [pat_pkg::AUX_N*DW-1:0] aux_delay,
   output logic breaker_fail_output,
   output logic alarm,
   output logic prot_trip,
   output logic prot_trip_pulse,
   output logic breaker_open_command,
   output logic breaker_close_command,
   output logic load_shed_flag,
   output logic [pat_pkg::AUX_N-1:0] aux_out,
   output logic [pat_pkg::DIR_N-1:0] direct_out,
   output logic phase_start_out,
   output logic earth_start_out
);
   localparam int AN = pat_pkg::AUX_N;
   localparam int MW = pat_pkg::AUX_MODE_W;
   localparam int TW = $clog2(TICK_CYC);

   typedef struct packed {
      logic [pat_pkg::SY_W-1:0] s1;
      logic [pat_pkg::SY_W-1:0] s2;
      logic [TW-1:0] tick_cnt;
      logic tick;
      logic bf_run;
      pat_pkg::pat_bf_src_t bf_src;
      logic [AN-1:0] latch;
      logic shed;
      logic bfo;
      logic alarm;
      logic trip;
      logic pulse;
      logic open_cmd;
      logic close_cmd;
      logic [AN-1:0] aux_out;
      logic [pat_pkg::DIR_N-1:0] direct_out;
      logic ph_start;
      logic ea_start;
   } pat_st_t;

   pat_st_t q;
   pat_st_t d;
   logic [AN-1:0] aux_exp;
   logic bf_exp;
   logic aux_trip;
   logic trip_lvl;
   logic alarm_lvl;
   logic open_lvl;
   logic close_lvl;
   logic shed_set;
   logic latch_clr;
   logic uc;
   logic bf_ext;
   pat_pkg::pat_aux_mode_t md;

   function automatic pat_pkg::pat_aux_mode_t mode_of(input int i,
         input logic [AN*MW-1:0] m);
      return pat_pkg::pat_aux_mode_t'(m[i*MW +: MW]);
   endfunction

   // Start condition of one auxiliary timer for its mode
   function automatic logic aux_runs(input pat_pkg::pat_aux_mode_t m,
         input logic in, input logic shed);
      unique case (m)
         pat_pkg::AUX_OFF: return 1'b0;
         pat_pkg::AUX_RECLOSE_AFTER_SHED_HIGH: return shed & in;
         pat_pkg::AUX_RECLOSE_AFTER_SHED_LOW: return shed & ~in;
         default: return in;
      endcase
   endfunction

   genvar g;
   generate
      for (g = 0; g < AN; g++) begin : g_aux
         pat_tmr_if #(.W(DW)) tif ();
         assign tif.run = aux_runs(mode_of(g, aux_mode),
            q.s2[pat_pkg::SY_AUX + g], q.shed);
         assign tif.tick = q.tick;
         assign tif.delay = aux_delay[g*DW +: DW];
         assign aux_exp[g] = tif.expired;
         pat_aux_timer #(.W(DW)) u_tmr (
            .clk(clk),
            .rstn(rstn),
            .ce(ce),
            .t(tif.tmr)
         );
      end
   endgenerate

   pat_tmr_if #(.W(DW)) bf_if ();
   assign bf_if.run = q.bf_run &&
      bf_mode != pat_pkg::BF_DISABLED;
   assign bf_if.tick = q.tick;
   assign bf_if.delay = breaker_fail_delay;
   assign bf_exp = bf_if.expired;
   pat_aux_timer #(.W(DW)) u_bf_tmr (
      .clk(clk),
      .rstn(rstn),
      .ce(ce),
      .t(bf_if.tmr)
   );

   always_comb begin
      d = q;
      md = pat_pkg::AUX_OFF;
      aux_trip = 1'b0;
      alarm_lvl = 1'b0;
      open_lvl = 1'b0;
      close_lvl = 1'b0;
      shed_set = 1'b0;
      d.s1 = {latch_reset_in, breaker_closed_contact,
         external_breaker_fail_start, direct_input_six,
         direct_input_five, aux_in};
      d.s2 = q.s1;
      if (q.tick_cnt == TW'(TICK_CYC - 1)) begin
         d.tick_cnt = '0;
         d.tick = 1'b1;
      end else begin
         d.tick_cnt = q.tick_cnt + 1'b1;
         d.tick = 1'b0;
      end
      latch_clr = q.s2[pat_pkg::SY_LRST] | panel_reset | remote_reset;
      for (int i = 0; i < AN; i++) begin
         md = mode_of(i, aux_mode);
         // Expiry sets the latch even in the cycle of a reset request
         d.latch[i] = (md == pat_pkg::AUX_LATCHED_TRIP) &
            (aux_exp[i] | (q.latch[i] & ~latch_clr));
         d.aux_out[i] = aux_exp[i] | d.latch[i];
         unique case (md)
            pat_pkg::AUX_ALARM: alarm_lvl |= aux_exp[i];
            pat_pkg::AUX_TRIP: aux_trip |= aux_exp[i];
            pat_pkg::AUX_INRUSH_BLOCKED_TRIP:
               aux_trip |= aux_exp[i] & ~inrush_block;
            pat_pkg::AUX_LATCHED_TRIP: aux_trip |= d.latch[i];
            pat_pkg::AUX_LOAD_SHED: begin
               open_lvl |= aux_exp[i];
               shed_set |= aux_exp[i];
            end
            pat_pkg::AUX_RECLOSE_AFTER_SHED_HIGH,
            pat_pkg::AUX_RECLOSE_AFTER_SHED_LOW:
               close_lvl |= aux_exp[i];
            pat_pkg::AUX_OFF: ;
         endcase
      end
      trip_lvl = int_trip | aux_trip |
         (q.bfo && bf_mode == pat_pkg::BF_RETRIP);
      alarm_lvl |= q.bfo && bf_mode == pat_pkg::BF_ALARM;
      uc = phase_undercurrent_level | earth_undercurrent_level;
      bf_ext = q.s2[pat_pkg::SY_EXT];
      if (!q.bf_run) begin
         if (int_trip) begin
            d.bf_run = 1'b1;
            d.bf_src = pat_pkg::BF_SRC_INT;
         end else if (bf_ext) begin
            d.bf_run = 1'b1;
            d.bf_src = pat_pkg::BF_SRC_EXT;
         end else if (aux_trip) begin
            d.bf_run = 1'b1;
            d.bf_src = pat_pkg::BF_SRC_AUX;
         end
      end else begin
         unique case (q.bf_src)
            pat_pkg::BF_SRC_INT,
            pat_pkg::BF_SRC_AUX: d.bf_run = ~uc;
            pat_pkg::BF_SRC_EXT: d.bf_run = bf_ext;
            default: d.bf_run = 1'b0;
         endcase
      end
      d.bfo = bf_exp;
      d.ph_start = phase_oc_start & ~(q.bfo & cancel_phase_en);
      d.ea_start = earth_oc_start & ~(q.bfo & cancel_earth_en);
      // Set wins over a clear arriving in the same cycle
      d.shed = shed_set | (q.shed & ~(trip_lvl | close_signal |
         q.close_cmd | q.s2[pat_pkg::SY_CLOSED]));
      d.trip = trip_lvl;
      d.pulse = trip_lvl & ~q.trip;
      d.alarm = alarm_lvl;
      d.open_cmd = open_lvl;
      d.close_cmd = close_lvl;
      d.direct_out = q.s2[pat_pkg::SY_DIR +: pat_pkg::DIR_N];
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         q <= '0;
      end else if (ce) begin
         q <= d;
      end
   end

   assign breaker_fail_output = q.bfo;
   assign alarm = q.alarm;
   assign prot_trip = q.trip;
   assign prot_trip_pulse = q.pulse;
   assign breaker_open_command = q.open_cmd;
   assign breaker_close_command = q.close_cmd;
   assign load_shed_flag = q.shed;
   assign aux_out = q.aux_out;
   assign direct_out = q.direct_out;
   assign phase_start_out = q.ph_start;
   assign earth_start_out = q.ea_start;

   chk_bf_start_trip: assert property (@(posedge clk)
      disable iff (!rstn) ce && !q.bf_run && int_trip |=> q.bf_run)
      else $error("trip did not start breaker-fail timing");
   chk_bf_out_expiry: assert property (@(posedge clk)
      disable iff (!rstn) ce && bf_exp |=> breaker_fail_output)
      else $error("breaker-fail expiry not shown");
   // Expiry drops one cycle after the run, the output one cycle later
   chk_bf_int_reset: assert property (@(posedge clk)
      disable iff (!rstn)
      ce && q.bf_run && q.bf_src == pat_pkg::BF_SRC_INT && uc
      |=> !q.bf_run ##2 !breaker_fail_output)
      else $error("undercurrent did not reset internal start");
   chk_bf_aux_reset: assert property (@(posedge clk)
      disable iff (!rstn)
      ce && q.bf_run && q.bf_src == pat_pkg::BF_SRC_AUX && uc
      |=> !q.bf_run)
      else $error("undercurrent did not reset aux start");
   chk_bf_ext_hold: assert property (@(posedge clk)
      disable iff (!rstn)
      ce && q.bf_run && q.bf_src == pat_pkg::BF_SRC_EXT
      |=> q.bf_run == $past(q.s2[pat_pkg::SY_EXT]))
      else $error("external start reset by wrong cause");
   chk_cancel_phase: assert property (@(posedge clk)
      disable iff (!rstn)
      ce && q.bfo && cancel_phase_en |=> !phase_start_out)
      else $error("phase start not cancelled");
   chk_cancel_earth: assert property (@(posedge clk)
      disable iff (!rstn)
      ce && q.bfo && cancel_earth_en |=> !earth_start_out)
      else $error("earth start not cancelled");
   chk_retrip_pulse: assert property (@(posedge clk)
      disable iff (!rstn)
      ce && q.bfo && bf_mode == pat_pkg::BF_RETRIP && !q.trip
      |=> prot_trip && prot_trip_pulse)
      else $error("retrip did not trip");
   chk_pulse_single: assert property (@(posedge clk)
      disable iff (!rstn) ce && prot_trip_pulse |=> !prot_trip_pulse)
      else $error("trip pulse stood longer than one cycle");
   chk_shed_set: assert property (@(posedge clk)
      disable iff (!rstn) ce && shed_set |=> load_shed_flag)
      else $error("load-shed flag not stored");
   chk_shed_clear: assert property (@(posedge clk)
      disable iff (!rstn)
      ce && !shed_set && close_signal |=> !load_shed_flag)
      else $error("close did not clear load-shed flag");
   chk_shed_closed: assert property (@(posedge clk)
      disable iff (!rstn)
      ce && !shed_set && q.s2[pat_pkg::SY_CLOSED] |=> !load_shed_flag)
      else $error("closed breaker did not clear load-shed flag");
   chk_direct_pass: assert property (@(posedge clk)
      disable iff (!rstn) ce ##1 ce ##1 ce
      |=> direct_out == $past({direct_input_six, direct_input_five}, 3))
      else $error("direct input not passed through");
endmodule
`default_nettype wire

//--- test/pat_breaker_model.sv
// Breaker model answering open and close commands with its closed contact
`timescale 1ns/100ps
`default_nettype none
module pat_breaker_model (
   input wire logic clk,
   input wire logic rstn,
   input wire logic open_cmd,
   input wire logic close_cmd,
   output logic closed
);
   logic closed_q;
   // Starts open so that a shed flag is not cleared by a stale closed contact
   always_ff @(posedge clk) begin
      if (!rstn) begin
         closed_q <= 1'b0;
      end else if (open_cmd) begin
         closed_q <= 1'b0;
      end else if (close_cmd) begin
         closed_q <= 1'b1;
      end
   end
   assign closed = closed_q;
endmodule
`default_nettype wire

//--- test/pat_top_tb_top.sv
// Self-checking bench of the protection auxiliary timer logic
`timescale 1ns/100ps
`default_nettype none
module pat_top_tb_top;
   localparam int TK = 10;
   logic clk, rstn, ce, d5, d6, ext, closed, lrst, prst, rrst, cls, itrip;
   logic poc, eoc, puc, euc, inr, cph, cea;
   logic [3:0] aux_in;
   logic [1:0] bf_mode;
   logic [19:0] bf_dly;
   logic [11:0] aux_mode;
   logic [79:0] aux_delay;
   logic bfo, alarm, trip, pulse, opc, clc, shed, pso, eso;
   logic [3:0] aux_out;
   logic [1:0] dir_out;
   int n_pulse, n_open, n_close, snap;
   logic [31:0] rng;
   int fails, tests_run, i, n, k;

   pat_top #(.TICK_CYC(TK)) pat_top_inst (.clk(clk), .rstn(rstn), .ce(ce),
      .aux_in(aux_in), .direct_input_five(d5), .direct_input_six(d6),
      .external_breaker_fail_start(ext), .breaker_closed_contact(closed),
      .latch_reset_in(lrst), .panel_reset(prst), .remote_reset(rrst),
      .close_signal(cls), .int_trip(itrip), .phase_oc_start(poc),
      .earth_oc_start(eoc), .phase_undercurrent_level(puc),
      .earth_undercurrent_level(euc), .inrush_block(inr), .bf_mode(bf_mode),
      .breaker_fail_delay(bf_dly), .cancel_phase_en(cph),
      .cancel_earth_en(cea), .aux_mode(aux_mode), .aux_delay(aux_delay),
      .breaker_fail_output(bfo), .alarm(alarm), .prot_trip(trip),
      .prot_trip_pulse(pulse), .breaker_open_command(opc),
      .breaker_close_command(clc), .load_shed_flag(shed), .aux_out(aux_out),
      .direct_out(dir_out), .phase_start_out(pso), .earth_start_out(eso));
   pat_breaker_model pat_breaker_model_inst (.clk(clk), .rstn(rstn),
      .open_cmd(opc), .close_cmd(clc), .closed(closed));

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // Event counts for outputs that may stand only one cycle
   always @(posedge clk) begin
      if (pulse) n_pulse <= n_pulse + 1;
      if (opc) n_open <= n_open + 1;
      if (clc) n_close <= n_close + 1;
   end

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] v;
      v = s ^ (s << 13);
      v = v ^ (v >> 17);
      return v ^ (v << 5);
   endfunction
   function automatic logic exp_trip(input logic [2:0] m, input logic b);
      return m == 3'h2 || (m == 3'h3 && !b);
   endfunction
   task automatic cyc(input int c);
      repeat (c) @(posedge clk);
      #2;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fails++;
         $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic print_verdict();
      $display("Checks %0d, mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic set_aux(input int t, input logic [2:0] m, input int d);
      aux_mode[3*t +: 3] = m;
      aux_delay[20*t +: 20] = 20'(d);
   endtask
   task automatic shed_event();
      aux_in[0] = 1'b1;
      cyc(6);
      aux_in[0] = 1'b0;
      cyc(6);
   endtask

   initial begin
      #400000;
      fails++;
      print_verdict();
   end

   initial begin
      {rstn, d5, d6, ext, lrst, prst, rrst, cls, itrip, poc, eoc} = '0;
      {puc, euc, inr, cph, cea} = '0;
      {aux_in, bf_mode, bf_dly, aux_mode, aux_delay} = '0;
      ce = 1'b1;
      fails = 0;
      tests_run = 0;
      rng = 32'hb8f6;
      cyc(4);
      rstn = 1'b1;
      cyc(1);
      for (k = 0; k < 6; k++) begin
         rng = xs(rng);
         {d6, d5} = rng[1:0];
         cyc(4);
         check(dir_out, rng[1:0]);
         check({alarm, trip}, 2'h0);
      end
      // Clock enable low freezes the pass-through
      ce = 1'b0;
      {d6, d5} = rng[1:0] ^ 2'h3;
      cyc(6);
      check(dir_out, rng[1:0]);
      ce = 1'b1;
      cyc(4);
      check(dir_out, rng[1:0] ^ 2'h3);
      for (k = 0; k < 4; k++) begin
         rng = xs(rng);
         i = rng[1:0];
         inr = (k == 2);
         set_aux(i, 3'(k + 1 - (k / 3)), 0);
         aux_in[i] = 1'b1;
         cyc(6);
         check(aux_out[i], 1'b1);
         check(alarm, k == 0);
         check(trip, exp_trip(aux_mode[3*i +: 3], inr));
         aux_in[i] = 1'b0;
         cyc(6);
         check(aux_out[i], 1'b0);
      end
      check(n_pulse != 0, 1'b1);
      rng = xs(rng);
      n = 2 + rng[7:0] % 5;
      set_aux(3, 3'h1, n);
      aux_in[3] = 1'b1;
      cyc((n - 1) * TK - 2);
      check(aux_out[3], 1'b0);
      aux_in[3] = 1'b0;
      cyc(6);
      aux_in[3] = 1'b1;
      cyc((n - 1) * TK - 2);
      check(aux_out[3], 1'b0);
      cyc(TK + 10);
      check(aux_out[3], 1'b1);
      aux_in[3] = 1'b0;
      set_aux(2, 3'h4, 0);
      for (k = 0; k < 3; k++) begin
         aux_in[2] = 1'b1;
         cyc(6);
         aux_in[2] = 1'b0;
         cyc(8);
         check({aux_out[2], trip}, 2'h3);
         {lrst, prst, rrst} = 3'(1 << k);
         cyc(1);
         {lrst, prst, rrst} = 3'h0;
         cyc(8);
         check({aux_out[2], trip}, 2'h0);
      end
      aux_mode = '0;
      set_aux(0, 3'h5, 0);
      set_aux(1, 3'h6, 0);
      snap = n_open;
      shed_event();
      check({n_open != snap, shed}, 2'h3);
      cls = 1'b1;
      cyc(1);
      cls = 1'b0;
      cyc(2);
      check(shed, 1'b0);
      shed_event();
      snap = n_close;
      aux_in[1] = 1'b1;
      cyc(8);
      check({n_close != snap, closed, shed}, 3'h6);
      set_aux(1, 3'h7, 0);
      shed_event();
      check(shed, 1'b1);
      snap = n_close;
      aux_in[1] = 1'b0;
      cyc(8);
      check({n_close != snap, shed}, 2'h2);
      // Undercurrent clears the start left by the earlier aux trips
      aux_mode = '0;
      puc = 1'b1;
      cyc(1);
      puc = 1'b0;
      {bf_mode, bf_dly, cph, cea, poc, eoc} = {2'h1, 20'h2, 4'hb};
      itrip = 1'b1;
      cyc(1);
      itrip = 1'b0;
      cyc(5);
      check(bfo, 1'b0);
      check({pso, eso}, 2'h3);
      cyc(2 * TK + 6);
      check({bfo, alarm}, 2'h3);
      check({pso, eso}, 2'h1);
      ext = 1'b1;
      puc = 1'b1;
      cyc(6);
      check(bfo, 1'b0);
      bf_mode = 2'h2;
      snap = n_pulse;
      cyc(2 * TK + 8);
      check({bfo, trip, n_pulse != snap}, 3'h7);
      ext = 1'b0;
      cyc(6);
      check(bfo, 1'b0);
      puc = 1'b0;
      set_aux(0, 3'h2, 0);
      aux_in[0] = 1'b1;
      cyc(6);
      aux_in[0] = 1'b0;
      cyc(2 * TK + 8);
      check(bfo, 1'b1);
      puc = 1'b1;
      cyc(6);
      check(bfo, 1'b0);
      print_verdict();
   end
endmodule
`default_nettype wire
